// ==== include/sso_cfg.svh ====
// Constants for the source select and oscillator trim block
`ifndef SSO_CFG_SVH
`define SSO_CFG_SVH
`define SSO_TRIM_W 20
`define SSO_TRIM_MIN 20'h00000
`define SSO_TRIM_MAX 20'hfffff
`define SSO_TRIM_MID 20'h80000
`define SSO_STEP_DEF 20'h02710
`define SSO_STEP_MIN 20'h00001
`define SSO_STEP_LIM 20'h088b8
// Synchroniser reset levels: ok pins absent, alarm pin idle high
`define SSO_PIN_RST 3'h1
`endif

// ==== include/sso_pkg.sv ====
// Types for the source select and oscillator trim block
`include "sso_cfg.svh"
package sso_pkg;
   typedef enum logic [1:0] {
      SSO_CMD_NONE = 2'b00,
      SSO_CMD_UP = 2'b01,
      SSO_CMD_DOWN = 2'b10,
      SSO_CMD_STEP = 2'b11
   } sso_trim_op_t;
   typedef struct packed {
      logic valid;
      sso_trim_op_t op;
      logic [`SSO_TRIM_W-1:0] value;
   } sso_trim_cmd_t;
   typedef struct packed {
      logic valid;
      logic pick_b;
   } sso_choose_cmd_t;
   typedef enum logic [1:0] {
      SSO_ON_A = 2'b00,
      SSO_ON_B = 2'b01,
      SSO_HELD_B = 2'b10
   } sso_sel_state_t;
endpackage

// ==== hw/sso_sync.sv ====
// Two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module sso_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // Reset to the pin's idle level, so no false event follows reset
         meta_r <= RST;
         q <= RST;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // sso_sync
`default_nettype wire

// ==== hw/sso_top.sv ====
// Source selector and oscillator trim word holder
// Behaviour
// - Query returns the applied trim word
// - Up adds step, down subtracts step
// - Step writable, resets to 10000
// - Exactly one input routed, never both
// - Both valid at default: choose A
// - Active input lost: switch over
// - After switch to B, stay on B
// - Twenty bit trim, step 1..35000 limited
// - Alarm on source A forces B
`timescale 1ns/1ps
`default_nettype none
`include "sso_cfg.svh"
module sso_top (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sig_ok_a,
   input wire logic sig_ok_b,
   input wire logic alarm_in_a_n,
   input wire sso_pkg::sso_trim_cmd_t trim_cmd,
   input wire sso_pkg::sso_choose_cmd_t source_choose_cmd,
   input wire logic auto_switch_enable_cmd,
   input wire logic auto_arg,
   input wire logic osc_trim_value_cmd,
   input wire logic step_limit_on,
   output logic [`SSO_TRIM_W-1:0] oscillator_trim_word,
   output logic [`SSO_TRIM_W-1:0] osc_trim_step,
   output logic [`SSO_TRIM_W-1:0] trim_query_data,
   output logic trim_query_valid,
   output logic route_a,
   output logic route_b,
   output logic auto_on
);
   import sso_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [2:0] pin_s;
   sso_sync #(.W(3), .RST(`SSO_PIN_RST)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d({sig_ok_a, sig_ok_b, alarm_in_a_n}),
      .q(pin_s)
   );
   logic ok_a, ok_b, alarm_a;
   assign ok_a = pin_s[2];
   assign ok_b = pin_s[1];
   assign alarm_a = ~pin_s[0];
   logic good_a;
   assign good_a = ok_a & ~alarm_a;

   // ==========================================================
   // Trim step
   logic [`SSO_TRIM_W-1:0] step_nxt;
   always_comb begin
      step_nxt = trim_cmd.value;
      if (step_nxt < `SSO_STEP_MIN)
         step_nxt = `SSO_STEP_MIN;
      else if (step_limit_on && step_nxt > `SSO_STEP_LIM)
         step_nxt = `SSO_STEP_LIM;
   end

   always_ff @(posedge clock) begin
      if (sys_rst)
         osc_trim_step <= `SSO_STEP_DEF;
      else if (trim_cmd.valid && trim_cmd.op == SSO_CMD_STEP)
         osc_trim_step <= step_nxt;
   end

   // ==========================================================
   // Trim word; 21-bit sums catch overflow for saturation
   logic [`SSO_TRIM_W:0] up_sum;
   logic [`SSO_TRIM_W:0] dn_dif;
   assign up_sum = {1'b0, oscillator_trim_word} + {1'b0, osc_trim_step};
   assign dn_dif = {1'b0, oscillator_trim_word} - {1'b0, osc_trim_step};

   always_ff @(posedge clock) begin
      if (sys_rst)
         oscillator_trim_word <= `SSO_TRIM_MID;
      else if (trim_cmd.valid && trim_cmd.op == SSO_CMD_UP)
         oscillator_trim_word <= up_sum[`SSO_TRIM_W] ? `SSO_TRIM_MAX
            : up_sum[`SSO_TRIM_W-1:0];
      else if (trim_cmd.valid && trim_cmd.op == SSO_CMD_DOWN)
         oscillator_trim_word <= dn_dif[`SSO_TRIM_W] ? `SSO_TRIM_MIN
            : dn_dif[`SSO_TRIM_W-1:0];
   end

   // ==========================================================
   // Query answer, one cycle after the query
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         trim_query_valid <= 1'b0;
         trim_query_data <= `SSO_TRIM_MIN;
      end else begin
         trim_query_valid <= osc_trim_value_cmd;
         if (osc_trim_value_cmd)
            trim_query_data <= oscillator_trim_word;
      end
   end

   // ==========================================================
   // Auto switch enable
   always_ff @(posedge clock) begin
      if (sys_rst)
         auto_on <= 1'b1;
      else if (auto_switch_enable_cmd)
         auto_on <= auto_arg;
   end

   // ==========================================================
   // Source selector
   sso_sel_state_t sel_r, sel_nxt;
   logic prefer_a_r;
   always_comb begin
      sel_nxt = sel_r;
      case (sel_r)
         SSO_ON_A: begin
            if (source_choose_cmd.valid && source_choose_cmd.pick_b)
               sel_nxt = SSO_ON_B;
            else if (auto_on && !good_a && ok_b)
               sel_nxt = SSO_HELD_B;
         end
         SSO_ON_B: begin
            if (source_choose_cmd.valid && !source_choose_cmd.pick_b)
               sel_nxt = SSO_ON_A;
            else if (auto_on && !ok_b && good_a)
               sel_nxt = SSO_ON_A;
         end
         SSO_HELD_B: begin
            // Held on B until select A then auto enable, or until B is lost while A is good
            if (source_choose_cmd.valid && !source_choose_cmd.pick_b)
               sel_nxt = SSO_ON_B;
            else if (auto_on && !ok_b && good_a)
               sel_nxt = SSO_ON_A;
         end
         default: sel_nxt = SSO_ON_A;
      endcase
      if (sel_r == SSO_ON_B && auto_switch_enable_cmd && auto_arg
          && !(source_choose_cmd.valid && source_choose_cmd.pick_b) && prefer_a_r)
         sel_nxt = SSO_ON_A;
   end

   always_ff @(posedge clock) begin
      if (sys_rst)
         prefer_a_r <= 1'b0;
      else if (source_choose_cmd.valid)
         prefer_a_r <= ~source_choose_cmd.pick_b;
   end

   always_ff @(posedge clock) begin
      if (sys_rst)
         sel_r <= SSO_ON_A;
      else
         sel_r <= sel_nxt;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         route_a <= 1'b1;
         route_b <= 1'b0;
      end else begin
         route_a <= (sel_nxt == SSO_ON_A);
         route_b <= (sel_nxt != SSO_ON_A);
      end
   end

   // ==========================================================
   // Checks
   chk_one_route: assert property (@(posedge clock) disable iff (sys_rst)
      route_a != route_b) else $error("route not one-hot");
   chk_step_reset: assert property (@(posedge clock)
      $fell(sys_rst) |-> osc_trim_step == `SSO_STEP_DEF)
      else $error("step reset wrong");
   chk_query_data: assert property (@(posedge clock) disable iff (sys_rst)
      osc_trim_value_cmd |=> trim_query_valid
      && trim_query_data == $past(oscillator_trim_word))
      else $error("query data wrong");
   chk_trim_up: assert property (@(posedge clock) disable iff (sys_rst)
      trim_cmd.valid && trim_cmd.op == SSO_CMD_UP |=>
      oscillator_trim_word >= $past(oscillator_trim_word))
      else $error("up lowered trim");
   chk_trim_down: assert property (@(posedge clock) disable iff (sys_rst)
      trim_cmd.valid && trim_cmd.op == SSO_CMD_DOWN |=>
      oscillator_trim_word <= $past(oscillator_trim_word))
      else $error("down raised trim");
   chk_step_limit: assert property (@(posedge clock) disable iff (sys_rst)
      step_limit_on && trim_cmd.valid && trim_cmd.op == SSO_CMD_STEP |=>
      osc_trim_step <= `SSO_STEP_LIM && osc_trim_step >= `SSO_STEP_MIN)
      else $error("step out of range");
   sequence s_held_b;
      sel_r == SSO_HELD_B;
   endsequence
   chk_hold_b: assert property (@(posedge clock) disable iff (sys_rst)
      s_held_b ##0 (ok_b && !source_choose_cmd.valid) |=> route_b)
      else $error("left held B");
   chk_alarm_b: assert property (@(posedge clock) disable iff (sys_rst)
      sel_r == SSO_ON_A && auto_on && alarm_a && ok_b
      && !source_choose_cmd.valid |=> route_b)
      else $error("alarm did not switch");
endmodule // sso_top
`default_nettype wire

// ==== verif/sso_term.sv ====
// Terminal model that sends trim and source commands
`timescale 1ns/1ps
`default_nettype none
module sso_term (
   input wire logic clock,
   output var sso_pkg::sso_trim_cmd_t trim_cmd,
   output var sso_pkg::sso_choose_cmd_t source_choose_cmd,
   output logic auto_switch_enable_cmd,
   output logic auto_arg,
   output logic osc_trim_value_cmd
);
   import sso_pkg::*;
   // =====
   // Command pulses
   // Idle value, pick_b and auto_arg fields show the inverse (trim op is kept) so stale values never look valid
   initial begin
      trim_cmd = '0;
      source_choose_cmd = '0;
      auto_switch_enable_cmd = 0;
      auto_arg = 0;
      osc_trim_value_cmd = 0;
   end
   task automatic trim(input sso_trim_op_t op, input logic [19:0] v);
      @(negedge clock);
      trim_cmd = '{1'b1, op, v};
      @(negedge clock);
      trim_cmd = '{1'b0, op, ~v};
   endtask
   task automatic choose(input logic b);
      @(negedge clock);
      source_choose_cmd = '{1'b1, b};
      @(negedge clock);
      source_choose_cmd = '{1'b0, ~b};
   endtask
   task automatic auto(input logic a);
      @(negedge clock);
      auto_switch_enable_cmd = 1;
      auto_arg = a;
      @(negedge clock);
      auto_switch_enable_cmd = 0;
      auto_arg = ~a;
   endtask
   task automatic query;
      @(negedge clock);
      osc_trim_value_cmd = 1;
      @(negedge clock);
      osc_trim_value_cmd = 0;
   endtask
endmodule // sso_term
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the source selector and trim holder
`timescale 1ns/1ps
`default_nettype none
`include "sso_cfg.svh"
module tb;
   import sso_pkg::*;
   logic clock = 0, sys_rst = 1, sig_ok_a = 1, sig_ok_b = 1;
   logic alarm_in_a_n = 1, step_limit_on = 1;
   sso_trim_cmd_t trim_cmd;
   sso_choose_cmd_t source_choose_cmd;
   logic auto_switch_enable_cmd, auto_arg, osc_trim_value_cmd;
   logic trim_query_valid, route_a, route_b, auto_on;
   logic [19:0] oscillator_trim_word, osc_trim_step, trim_query_data;
   int miscompares = 0, checked = 0, cycles = 0;
   always #2.5 clock = ~clock;
   sso_top i_sso_top (.clock, .sys_rst, .sig_ok_a, .sig_ok_b, .alarm_in_a_n,
      .trim_cmd, .source_choose_cmd, .auto_switch_enable_cmd, .auto_arg,
      .osc_trim_value_cmd, .step_limit_on, .oscillator_trim_word, .osc_trim_step,
      .trim_query_data, .trim_query_valid, .route_a, .route_b, .auto_on);
   sso_term i_sso_term (.clock, .trim_cmd, .source_choose_cmd,
      .auto_switch_enable_cmd, .auto_arg, .osc_trim_value_cmd);
   // =====
   // Checks
   task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Pins pass a synchroniser, so allow a bounded settling time
   task automatic wait_b(input logic e);
      for (int i = 0; i < 12 && route_b !== e; i++) @(negedge clock);
      cmp("route_b", {19'h0, e}, {19'h0, route_b});
      cmp("route_a", {19'h0, !e}, {19'h0, route_a});
   endtask
   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict;
      end
   end
   // =====
   // Scenarios
   task automatic t_trim;
      cmp("trim", `SSO_TRIM_MID, oscillator_trim_word);
      cmp("step", `SSO_STEP_DEF, osc_trim_step);
      i_sso_term.trim(SSO_CMD_UP, 20'h0);
      i_sso_term.query;
      cmp("valid", 20'h1, {19'h0, trim_query_valid});
      cmp("query", `SSO_TRIM_MID + `SSO_STEP_DEF, trim_query_data);
      i_sso_term.trim(SSO_CMD_DOWN, 20'h0);
      cmp("trim", `SSO_TRIM_MID, oscillator_trim_word);
      $display("test trim done");
   endtask
   task automatic t_step;
      i_sso_term.trim(SSO_CMD_STEP, 20'h0);
      cmp("step", `SSO_STEP_MIN, osc_trim_step);
      i_sso_term.trim(SSO_CMD_STEP, 20'h003e8);
      cmp("step", 20'h003e8, osc_trim_step);
      i_sso_term.trim(SSO_CMD_STEP, 20'hfffff);
      cmp("step", `SSO_STEP_LIM, osc_trim_step);
      repeat (16) i_sso_term.trim(SSO_CMD_UP, 20'h0);
      cmp("trim", `SSO_TRIM_MAX, oscillator_trim_word);
      repeat (32) i_sso_term.trim(SSO_CMD_DOWN, 20'h0);
      cmp("trim", `SSO_TRIM_MIN, oscillator_trim_word);
      step_limit_on = 0;
      i_sso_term.trim(SSO_CMD_STEP, 20'h09c40);
      cmp("step", 20'h09c40, osc_trim_step);
      step_limit_on = 1;
      i_sso_term.trim(SSO_CMD_STEP, `SSO_STEP_DEF);
      cmp("step", `SSO_STEP_DEF, osc_trim_step);
      $display("test step done");
   endtask
   task automatic t_source;
      wait_b(0);
      sig_ok_a = 0;
      wait_b(1);
      sig_ok_a = 1;
      repeat (10) @(negedge clock);
      wait_b(1);
      i_sso_term.choose(0);
      i_sso_term.auto(1);
      wait_b(0);
      alarm_in_a_n = 0;
      wait_b(1);
      alarm_in_a_n = 1;
      i_sso_term.choose(0);
      i_sso_term.auto(1);
      wait_b(0);
      $display("test source done");
   endtask
   task automatic t_manual;
      cmp("auto_on", 20'h1, {19'h0, auto_on});
      i_sso_term.choose(1);
      wait_b(1);
      sig_ok_b = 0;
      wait_b(0);
      sig_ok_b = 1;
      i_sso_term.auto(0);
      cmp("auto_on", 20'h0, {19'h0, auto_on});
      sig_ok_a = 0;
      repeat (10) @(negedge clock);
      wait_b(0);
      i_sso_term.auto(1);
      cmp("auto_on", 20'h1, {19'h0, auto_on});
      wait_b(1);
      sig_ok_a = 1;
      i_sso_term.auto(1);
      repeat (4) @(negedge clock);
      wait_b(1);
      i_sso_term.choose(0);
      i_sso_term.auto(1);
      wait_b(0);
      $display("test manual done");
   endtask
   initial begin
      repeat (20) @(negedge clock);
      sys_rst = 0;
      @(negedge clock);
      t_trim;
      t_step;
      t_source;
      t_manual;
      print_verdict;
   end
endmodule // tb
`default_nettype wire
